// ==== hw_master_volume_control.sv ====
`timescale 1ns/1ps
`include "hwvol_cfg.svh"
module hw_master_volume_control #(
  parameter int DEB_LONG_CYC = `DEB_LONG_MS * 1000 * `CLK_MHZ,
  parameter int HOLD_CYC     = `HOLD_MS * 1000 * `CLK_MHZ,
  parameter int REPEAT_CYC   = `REPEAT_MS * 1000 * `CLK_MHZ
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  input  wire logic                  volume_raise_button_n,
  input  wire logic                  volume_lower_button_n,
  input  wire logic                  split_mode,
  input  wire logic                  irq_mask,
  input  wire logic                  fast_debounce,
  input  wire logic                  big_step,
  input  wire logic                  xlate_en,
  input  wire hwvol_pkg::legacy_wr_t leg_wr,
  input  wire logic                  irq_clear,
  output hwvol_pkg::mvol_t           master_vol,
  output hwvol_pkg::mvol_t           hw_counter,
  output logic                       irq_pending,
  output logic                       hw_irq,
  output logic [7:0]                 legacy_rd22,
  output logic [7:0]                 legacy_rd32
);
  import hwvol_pkg::*;

  localparam int DEB_SHORT_CYC = `DEB_SHORT_US * `CLK_MHZ;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // saturating step, never wraps
  function automatic logic [5:0] sat_step(input logic [5:0] v, input logic up,
                                          input logic [1:0] sz);
    logic [5:0] s;
    s = {4'h0, sz};
    if (up)
      sat_step = (v > `VOL_MAX - s) ? `VOL_MAX : v + s;
    else
      sat_step = (v < s) ? `VOL_MIN : v - s;
  endfunction : sat_step

  // legacy byte to master word; zero on both channels means mute
  function automatic mvol_t expand(input logic sel, input logic [7:0] d);
    mvol_t m;
    if (sel == `SEL_REG22)
    begin
      m.left  = {d[7:5], d[7:5]};
      m.right = {d[3:1], d[3:1]};
      m.mute  = (d[7:5] == 3'h0) && (d[3:1] == 3'h0);
    end
    else
    begin
      m.left  = {d[7:4], d[7:6]};
      m.right = {d[3:0], d[3:2]};
      m.mute  = (d == 8'h00);
    end
    expand = m;
  endfunction : expand

  // master word to legacy byte; mute reads as zero volume
  function automatic logic [7:0] shrink(input logic sel, input mvol_t m);
    if (m.mute)
      shrink = 8'h00;
    else if (sel == `SEL_REG22)
      shrink = {m.left[5:3], 1'b0, m.right[5:3], 1'b0};
    else
      shrink = {m.left[5:2], m.right[5:2]};
  endfunction : shrink

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;

  // pins idle high through the pull-ups
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
    end
    else if (clk_en)
    begin
      sync1_reg <= {volume_lower_button_n, volume_raise_button_n};
      sync2_reg <= sync1_reg;
    end

  // ----------------------------------------
  // debounce
  // ----------------------------------------
  logic [1:0]  pressed_reg;
  logic [1:0]  pressed_next;
  logic [27:0] deb_cnt_reg  [2];
  logic [27:0] deb_cnt_next [2];
  logic [27:0] deb_limit;

  assign deb_limit = fast_debounce ? 28'(DEB_SHORT_CYC) : 28'(DEB_LONG_CYC);

  // same limit for press and release, so the high gap is qualified too
  always_comb
  begin
    pressed_next = pressed_reg;
    for (int i = 0; i < 2; i++)
    begin
      deb_cnt_next[i] = 28'h0;
      if (!sync2_reg[i] != pressed_reg[i])
      begin
        deb_cnt_next[i] = deb_cnt_reg[i] + 28'h1;
        if (deb_cnt_reg[i] + 28'h1 >= deb_limit)
        begin
          pressed_next[i] = !pressed_reg[i];
          deb_cnt_next[i] = 28'h0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      pressed_reg    <= 2'h0;
      deb_cnt_reg[0] <= 28'h0;
      deb_cnt_reg[1] <= 28'h0;
    end
    else if (clk_en)
    begin
      pressed_reg    <= pressed_next;
      deb_cnt_reg[0] <= deb_cnt_next[0];
      deb_cnt_reg[1] <= deb_cnt_next[1];
    end

  // ----------------------------------------
  // press sequencer
  // ----------------------------------------
  hv_state_t   state_reg;
  hv_state_t   state_next;
  logic [27:0] tmr_reg;
  logic [27:0] tmr_next;
  logic        step_ev;
  logic        step_up;
  logic [1:0]  step_sz;
  logic        mute_ev;

  // mute is checked first so a two-button press seen in one cycle never steps; a second button arriving later mutes after the first step
  always_comb
  begin
    state_next = state_reg;
    tmr_next   = tmr_reg;
    step_ev    = 1'b0;
    step_up    = pressed_reg[0];
    step_sz    = `STEP_SMALL;
    mute_ev    = 1'b0;
    unique case (state_reg)
      ST_IDLE:
        if (&pressed_reg)
        begin
          mute_ev    = 1'b1;
          state_next = ST_MUTE;
        end
        else if (|pressed_reg)
        begin
          step_ev    = 1'b1;
          step_sz    = big_step ? `STEP_LARGE : `STEP_SMALL;
          tmr_next   = 28'h0;
          state_next = ST_WAIT;
        end
      ST_WAIT, ST_SCROLL:
        if (&pressed_reg)
        begin
          mute_ev    = 1'b1;
          state_next = ST_MUTE;
        end
        else if (!(|pressed_reg))
          state_next = ST_IDLE;
        else if (tmr_reg + 28'h1 >= ((state_reg == ST_WAIT) ? 28'(HOLD_CYC) : 28'(REPEAT_CYC)))
        begin
          tmr_next   = 28'h0;
          state_next = ST_SCROLL;
          step_ev    = (state_reg == ST_SCROLL);
        end
        else
          tmr_next = tmr_reg + 28'h1;
      ST_MUTE:
        // wait for both buttons to let go before a new action
        if (!(|pressed_reg))
          state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      state_reg <= ST_IDLE;
      tmr_reg   <= 28'h0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      tmr_reg   <= tmr_next;
    end

  // ----------------------------------------
  // volume registers and interrupt
  // ----------------------------------------
  mvol_t      master_reg;
  mvol_t      master_next;
  mvol_t      counter_reg;
  mvol_t      counter_next;
  mvol_t      wr_val;
  logic       hw_event;
  logic       irq_next;
  logic       irq_pending_reg;
  logic [7:0] rd22_reg;
  logic [7:0] rd32_reg;

  assign hw_event = step_ev | mute_ev;
  assign wr_val   = expand(leg_wr.sel, leg_wr.data);

  // a legacy write in the same cycle as a button action wins on the master
  always_comb
  begin
    master_next  = master_reg;
    counter_next = counter_reg;
    if (split_mode)
    begin
      if (step_ev)
      begin
        counter_next.left  = sat_step(counter_reg.left, step_up, step_sz);
        counter_next.right = sat_step(counter_reg.right, step_up, step_sz);
      end
      if (mute_ev)
        counter_next.mute = !counter_reg.mute;
    end
    else
    begin
      if (step_ev)
      begin
        master_next.left  = sat_step(master_reg.left, step_up, step_sz);
        master_next.right = sat_step(master_reg.right, step_up, step_sz);
      end
      if (mute_ev)
        master_next.mute = !master_reg.mute;
    end
    if (leg_wr.valid && xlate_en)
      master_next = wr_val;
    // set wins over a clear in the same cycle, so no event is lost
    irq_next = (irq_pending_reg && !irq_clear) || hw_event;
  end

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      master_reg      <= '{mute: 1'b0, left: `VOL_RESET, right: `VOL_RESET};
      counter_reg     <= '{mute: 1'b0, left: `VOL_RESET, right: `VOL_RESET};
      irq_pending_reg <= 1'b0;
      rd22_reg        <= 8'h00;
      rd32_reg        <= 8'h00;
    end
    else if (clk_en)
    begin
      master_reg      <= master_next;
      counter_reg     <= counter_next;
      irq_pending_reg <= irq_next;
      rd22_reg        <= shrink(`SEL_REG22, master_next);
      rd32_reg        <= shrink(`SEL_REG32, master_next);
    end

  assign master_vol  = master_reg;
  assign hw_counter  = counter_reg;
  assign irq_pending = irq_pending_reg;
  assign hw_irq      = irq_pending_reg && irq_mask;
  assign legacy_rd22 = rd22_reg;
  assign legacy_rd32 = rd32_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic quiet_wr;
  assign quiet_wr = !(leg_wr.valid && xlate_en);

  chk_mute_both: assert property (
    clk_en && mute_ev && !split_mode && quiet_wr |=> master_reg.mute != $past(master_reg.mute))
    else $error("mute toggle missing");
  chk_single_step: assert property (
    clk_en && state_reg == ST_IDLE && pressed_reg == 2'h1 && !big_step && !split_mode
    && quiet_wr && master_reg.left < `VOL_MAX |=> master_reg.left == $past(master_reg.left) + 6'h1)
    else $error("single step wrong");
  chk_big_step: assert property (
    clk_en && state_reg == ST_IDLE && pressed_reg == 2'h1 && big_step && !split_mode
    && quiet_wr && master_reg.left < 6'h3C |=> master_reg.left == $past(master_reg.left) + 6'h3)
    else $error("large step wrong");
  chk_scroll_unit: assert property (
    clk_en && state_reg == ST_SCROLL && step_ev && !split_mode && quiet_wr
    && master_reg.right > `VOL_MIN && !step_up |=> master_reg.right == $past(master_reg.right) - 6'h1)
    else $error("scroll step wrong");
  chk_debounce_len: assert property (
    clk_en && pressed_next[0] != pressed_reg[0] |-> deb_cnt_reg[0] + 28'h1 >= deb_limit)
    else $error("press accepted early");
  chk_fast_limit: assert property (
    fast_debounce |-> deb_limit == 28'h7D0)
    else $error("fast debounce limit wrong");
  chk_event_irq: assert property (
    clk_en && hw_event |=> irq_pending_reg ##0 hw_irq == irq_mask)
    else $error("event raised no interrupt");
  chk_split_hold: assert property (
    clk_en && split_mode && quiet_wr |=> master_reg == $past(master_reg))
    else $error("split mode touched master");
  chk_legacy_wr: assert property (
    clk_en && !quiet_wr |=> master_reg == $past(wr_val))
    else $error("legacy write not applied");
  chk_xlate_off: assert property (
    clk_en && !xlate_en && !hw_event |=> master_reg == $past(master_reg))
    else $error("disabled translation changed master");
  chk_read_back: assert property (
    clk_en |=> legacy_rd32 == shrink(`SEL_REG32, master_reg))
    else $error("legacy read mismatch");
  chk_irq_clear: assert property (
    clk_en && irq_clear && !hw_event |=> !irq_pending)
    else $error("clear did not clear");
  chk_floor_hold: assert property (
    clk_en && step_ev && !step_up && !split_mode && quiet_wr && master_reg.left == `VOL_MIN
    |=> master_reg.left == `VOL_MIN)
    else $error("volume wrapped");

  cov_mute: cover property (clk_en && mute_ev);
  cov_scroll: cover property (clk_en && state_reg == ST_SCROLL && step_ev);
  cov_split: cover property (clk_en && split_mode && step_ev);
  cov_legacy: cover property (clk_en && !quiet_wr ##1 clk_en && hw_event);
endmodule : hw_master_volume_control

// ==== hwvol_cfg.svh ====
`ifndef HWVOL_CFG_SVH
`define HWVOL_CFG_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ       200
`define DEB_LONG_MS   40
`define DEB_SHORT_US  10
`define HOLD_MS       500
`define REPEAT_MS     50
// ----------------------------------------
// volume codes and steps
// ----------------------------------------
`define VOL_MAX       6'h3F
`define VOL_MIN       6'h00
`define VOL_RESET     6'h20
`define STEP_SMALL    2'h1
`define STEP_LARGE    2'h3
// ----------------------------------------
// legacy register selection
// ----------------------------------------
`define SEL_REG22     1'b0
`define SEL_REG32     1'b1
`endif

// ==== hwvol_pkg.sv ====
package hwvol_pkg;
  // master volume word: 6-bit per channel plus mute
  typedef struct packed {
    logic       mute;
    logic [5:0] left;
    logic [5:0] right;
  } mvol_t;
  // legacy mixer write: sel 0 is the 3-bit register, 1 the 4-bit one
  typedef struct packed {
    logic       valid;
    logic       sel;
    logic [7:0] data;
  } legacy_wr_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SCROLL, ST_MUTE} hv_state_t;
endpackage : hwvol_pkg

// ==== push_button_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// momentary switch to ground, pulled up
// ----------------------------------------
module push_button_model (
  input  wire logic ref_clk,
  input  wire logic press,
  output logic      pin_n
);
  logic last_press = 1'b0;
  int   bounce     = 0;
  // contacts chatter a few cycles per change, well under any debounce limit
  always @(posedge ref_clk)
  begin
    last_press <= press;
    if (press !== last_press)
      bounce <= 4;
    else if (bounce > 0)
      bounce <= bounce - 1;
    pin_n <= (bounce > 0) ? ~pin_n : ~press; // pull-up wins when open
  end
  initial pin_n = 1'b1;
endmodule : push_button_model

// ==== test_hw_master_volume_control.sv ====
`timescale 1ns/1ps
module test_hw_master_volume_control;
  import hwvol_pkg::*;
  localparam int DEB = 20;
  logic       ref_clk = 1'b0;
  logic       rst     = 1'b1;
  logic       split_mode, irq_mask, fast_debounce, big_step, xlate_en, irq_clear;
  logic       press_up, press_dn;
  logic       up_n, dn_n, irq_pending, hw_irq;
  logic [7:0] legacy_rd22, legacy_rd32, prev;
  legacy_wr_t leg_wr;
  mvol_t      master_vol, hw_counter;
  int         fail_count, samples_checked, cycles, steps;
  logic [8:0]  wr_tab [4] = '{9'h1FF, 9'h0A4, 9'h100, 9'h188};
  logic [12:0] mv_tab [4] = '{13'h0FFF, 13'h0B52, 13'h1000, 13'h08A2};
  logic [7:0]  r22_tab [4] = '{8'hEE, 8'hA4, 8'h00, 8'h88};
  logic [7:0]  r32_tab [4] = '{8'hFF, 8'hB4, 8'h00, 8'h88};

  always #2.5 ref_clk = ~ref_clk;

  push_button_model btn_up (.ref_clk(ref_clk), .press(press_up), .pin_n(up_n));
  push_button_model btn_dn (.ref_clk(ref_clk), .press(press_dn), .pin_n(dn_n));

  // short counts keep the run small; the fast debounce value is fixed
  hw_master_volume_control #(.DEB_LONG_CYC(DEB), .HOLD_CYC(60), .REPEAT_CYC(15))
    i_hw_master_volume_control (.ref_clk(ref_clk), .rst(rst), .clk_en(1'b1),
    .volume_raise_button_n(up_n), .volume_lower_button_n(dn_n), .split_mode(split_mode),
    .irq_mask(irq_mask), .fast_debounce(fast_debounce), .big_step(big_step),
    .xlate_en(xlate_en), .leg_wr(leg_wr), .irq_clear(irq_clear), .master_vol(master_vol),
    .hw_counter(hw_counter), .irq_pending(irq_pending), .hw_irq(hw_irq),
    .legacy_rd22(legacy_rd22), .legacy_rd32(legacy_rd32));

  function automatic mvol_t mv(input logic [5:0] l);
    return '{mute: 1'b0, left: l, right: l};
  endfunction : mv

  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  task automatic cmp_vol(input string n, input mvol_t e, input mvol_t g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_vol

  task automatic cmp_val(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_val

  // hold the switches, then give the release its own debounce time
  task automatic press(input logic up, input logic dn, input int hold);
    @(posedge ref_clk);
    press_up <= up;
    press_dn <= dn;
    repeat (hold) @(posedge ref_clk);
    press_up <= 1'b0;
    press_dn <= 1'b0;
    repeat (2 * DEB + 10) @(posedge ref_clk);
    #1;
  endtask : press

  task automatic leg_write(input logic [8:0] w);
    @(posedge ref_clk);
    leg_wr <= '{valid: 1'b1, sel: w[8], data: w[7:0]};
    @(posedge ref_clk);
    leg_wr <= '{valid: 1'b0, sel: 1'b0, data: 8'h00};
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : leg_write

  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    {split_mode, irq_mask, big_step, xlate_en} = 4'hF;
    {fast_debounce, irq_clear, press_up, press_dn} = 4'h0;
    leg_wr = '0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    big_step <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_vol("reset master", mv(6'h20), master_vol);
    cmp_val("reset rd22", 8'h88, legacy_rd22);
    press(1'b0, 1'b1, 40);
    cmp_vol("split counter", mv(6'h1F), hw_counter);
    cmp_vol("split master", mv(6'h20), master_vol);
    cmp_val("split irq", 8'h01, {7'h00, hw_irq});
    @(posedge ref_clk);
    irq_clear <= 1'b1;
    irq_mask <= 1'b0;
    split_mode <= 1'b0;
    @(posedge ref_clk);
    irq_clear <= 1'b0;
    #1;
    cmp_val("cleared", 8'h00, {7'h00, irq_pending});
    press(1'b1, 1'b0, 10); // low too briefly to count
    cmp_vol("glitch", mv(6'h20), master_vol);
    press(1'b1, 1'b0, 40);
    cmp_vol("step up", mv(6'h21), master_vol);
    cmp_val("pending", 8'h01, {7'h00, irq_pending});
    cmp_val("masked", 8'h00, {7'h00, hw_irq});
    for (int i = 0; i < 4; i++)
    begin
      leg_write(wr_tab[i]);
      cmp_vol("legacy master", mvol_t'(mv_tab[i]), master_vol);
      cmp_val("rd22", r22_tab[i], legacy_rd22);
      cmp_val("rd32", r32_tab[i], legacy_rd32);
    end
    xlate_en <= 1'b0;
    leg_write(9'h1FF);
    cmp_vol("xlate off", mv(6'h22), master_vol);
    xlate_en <= 1'b1;
    press(1'b1, 1'b1, 40);
    cmp_vol("mute on", '{mute: 1'b1, left: 6'h22, right: 6'h22}, master_vol);
    press(1'b1, 1'b1, 40);
    cmp_vol("mute off", mv(6'h22), master_vol);
    // large first step, then single units while held
    big_step <= 1'b1;
    @(posedge ref_clk);
    press_up <= 1'b1;
    prev = 8'h22;
    steps = 0;
    // keep watching through the release debounce, where scrolling still runs
    for (int k = 0; k < 260; k++)
    begin
      @(posedge ref_clk);
      if (k == 200)
        press_up <= 1'b0;
      #1;
      if ({2'b00, master_vol.left} !== prev)
      begin
        cmp_val("delta", (steps == 0) ? 8'h03 : 8'h01, {2'b00, master_vol.left} - prev);
        prev = {2'b00, master_vol.left};
        steps++;
      end
    end
    press(1'b0, 1'b0, 1);
    cmp_val("scrolled", 8'h01, {7'h00, steps > 2});
    cmp_vol("both channels", mv(prev[5:0]), master_vol);
    leg_write(9'h1FF);
    press(1'b1, 1'b0, 40);
    cmp_vol("saturate", mv(6'h3F), master_vol);
    fast_debounce <= 1'b1;
    @(posedge ref_clk);
    press_dn <= 1'b1;
    repeat (1990) @(posedge ref_clk);
    #1;
    cmp_vol("fast early", mv(6'h3F), master_vol);
    for (int i = 0; i < 60 && master_vol !== mv(6'h3C); i++)
      @(posedge ref_clk);
    #1;
    cmp_vol("fast press", mv(6'h3C), master_vol);
    stop_test();
  end
endmodule : test_hw_master_volume_control
